// File: shared/mahpm_pkg.sv
package mahpm_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_STATION_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFF_GROUP_HASH_HIGH = 8'h0C;
  localparam logic [7:0] OFF_GROUP_HASH_LOW = 8'h10;
  localparam logic [7:0] OFF_PHY_MGMT_COMMAND = 8'h14;
  localparam logic [7:0] OFF_PHY_MGMT_DATA = 8'h18;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_STATION_ADDR_LOW = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_GROUP_HASH_HIGH = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_GROUP_HASH_LOW = 32'h0000_0000;
  localparam logic [4:0] RST_PHY_SELECT = 5'h0B;
  localparam logic [4:0] RST_PHY_REG_SELECT = 5'h0B;
  localparam logic [15:0] RST_MGMT_DATA = 16'h0000;

  // ----------------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------------
  localparam int PHY_SEL_LSB = 11;
  localparam int REG_SEL_LSB = 6;
  localparam int WRITE_SEL_BIT = 1;
  localparam int IN_PROGRESS_BIT = 0;

  // ----------------------------------------------------------------------
  // management frame layout and timing
  // ----------------------------------------------------------------------
  localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam int FRAME_BITS = 64;
  localparam int TA_BIT = 46;
  localparam int DATA_BIT = 48;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MDC_PERIOD_NS = 400;
  localparam int MDC_HALF_CYC =
    (MDC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] phy_select;
    logic [4:0] phy_reg_select;
    logic mgmt_write_select;
  } mahpm_cmd_type;

  typedef struct packed {
    logic accept;
    logic valid;
  } mahpm_filt_type;

endpackage : mahpm_pkg

// File: rtl/mahpm_hash_filter.sv
`timescale 1ns/1ns
module mahpm_hash_filter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // destination address under test
  input wire logic [47:0] dest_addr,
  input wire logic dest_valid,
  // table and verdict
  input wire logic [63:0] group_hash_bits,
  output mahpm_pkg::mahpm_filt_type verdict
);

  // ----------------------------------------------------------------------
  // crc over the destination, first octet first, lsb first
  // ----------------------------------------------------------------------
  function automatic logic [31:0] dest_crc(input logic [47:0] da);
    logic [31:0] c;
    logic fb;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < 48; i++) begin
      fb = c[31] ^ da[47 - 8 * (i / 8) - 7 + (i % 8)];
      c = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ 32'h04C1_1DB7;
      end
    end
    return c;
  endfunction : dest_crc

  logic [31:0] crc;
  logic [5:0] hash_index;
  mahpm_pkg::mahpm_filt_type verdict_r;

  assign crc = dest_crc(dest_addr);
  assign hash_index = crc[31:26];
  assign verdict = verdict_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verdict_r <= '0;
    end else begin
      verdict_r.valid <= dest_valid;
      verdict_r.accept <= dest_valid & group_hash_bits[hash_index];
    end
  end

  chk_hash_lookup: assert property (
    @(posedge pclk) disable iff (!presetn)
    dest_valid |=> verdict_r.valid &&
      verdict_r.accept == $past(group_hash_bits[hash_index]))
    else $error("multicast verdict does not match the indexed table bit");

  cov_accept: cover property (
    @(posedge pclk) disable iff (!presetn) verdict_r.valid && verdict_r.accept);

endmodule : mahpm_hash_filter

// File: rtl/mahpm_regs.sv
`timescale 1ns/1ns
// What this block does
// - upper group hash register holds table bits 63..32, resets to ones.
// - lower group hash register holds table bits 31..0, resets to zeros.
// - bits 15..11 of the command register pick one of 32 phys.
// - bits 10..6 pick the register inside the chosen phy.
// - bit 1 picks direction: one writes the phy, zero reads it.
// - bit 0 reads one while a management transaction runs.
// - bit 0 clears at the end; read data is then in the data register.
// - only the first mac instance has a working command register.
// - the 16-bit data field holds write data or receives read data.
module mahpm_regs #(
  parameter bit IS_FIRST_MAC = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mahpm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // management bus
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // receive filtering
  input wire logic [47:0] dest_addr,
  input wire logic dest_valid,
  output logic [31:0] station_addr_bits,
  output mahpm_pkg::mahpm_filt_type mcast_verdict
);

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] station_addr_r;
  logic [31:0] hash_high_r;
  logic [31:0] hash_low_r;
  mahpm_pkg::mahpm_cmd_type cmd_r;
  logic [15:0] mgmt_data_r;

  typedef enum logic {MG_IDLE, MG_RUN} mahpm_state_type;
  mahpm_state_type state_r;

  wire setup_ph = psel & ~penable;
  wire access_done = psel & penable & pready_r;
  wire wr_en = access_done & pwrite;
  wire sel_station = paddr == mahpm_pkg::OFF_STATION_ADDR_LOW;
  wire sel_hash_hi = paddr == mahpm_pkg::OFF_GROUP_HASH_HIGH;
  wire sel_hash_lo = paddr == mahpm_pkg::OFF_GROUP_HASH_LOW;
  wire sel_cmd = paddr == mahpm_pkg::OFF_PHY_MGMT_COMMAND;
  wire sel_data = paddr == mahpm_pkg::OFF_PHY_MGMT_DATA;
  wire addr_ok = sel_station | sel_hash_hi | sel_hash_lo | sel_cmd | sel_data;
  wire mgmt_idle = state_r == MG_IDLE;
  wire mgmt_busy = state_r == MG_RUN;

  // copies in later mac instances accept writes and do nothing
  wire cmd_we = wr_en & sel_cmd & IS_FIRST_MAC & mgmt_idle;
  wire data_we = wr_en & sel_data & IS_FIRST_MAC & mgmt_idle;
  wire mgmt_start = cmd_we;

  wire [31:0] cmd_view = IS_FIRST_MAC ? {16'h0000,
    cmd_r.phy_select, cmd_r.phy_reg_select, 4'h0,
    cmd_r.mgmt_write_select, mgmt_busy} : 32'h0000_0000;
  wire [31:0] data_view = IS_FIRST_MAC ? {16'h0000, mgmt_data_r}
    : 32'h0000_0000;

  wire [31:0] rd_mux = sel_station ? station_addr_r :
    sel_hash_hi ? hash_high_r :
    sel_hash_lo ? hash_low_r :
    sel_cmd ? cmd_view :
    sel_data ? data_view : 32'h0000_0000;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // one access cycle for every transfer; no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & ~addr_ok;
      if (setup_ph) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // address and hash registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_addr_r <= mahpm_pkg::RST_STATION_ADDR_LOW;
      hash_high_r <= mahpm_pkg::RST_GROUP_HASH_HIGH;
      hash_low_r <= mahpm_pkg::RST_GROUP_HASH_LOW;
    end else begin
      if (wr_en & sel_station) begin
        station_addr_r <= pwdata;
      end
      if (wr_en & sel_hash_hi) begin
        hash_high_r <= pwdata;
      end
      if (wr_en & sel_hash_lo) begin
        hash_low_r <= pwdata;
      end
    end
  end

  assign station_addr_bits = station_addr_r;

  // ----------------------------------------------------------------------
  // management command and data
  // ----------------------------------------------------------------------
  logic [4:0] ph_r;
  logic [6:0] bit_idx_r;
  logic [63:0] tx_shift_r;
  logic [15:0] rx_shift_r;
  logic mdio_meta_r;
  logic mdio_sync_r;
  logic mdc_r;
  logic mdio_out_r;
  logic mdio_oe_r;

  wire [4:0] half_cyc = 5'(mahpm_pkg::MDC_HALF_CYC);
  wire [4:0] last_ph = 5'(2 * mahpm_pkg::MDC_HALF_CYC - 1);
  wire low_end = mgmt_busy & (ph_r == half_cyc - 5'd1);
  wire bit_end = mgmt_busy & (ph_r == last_ph);
  wire frame_end = bit_end & (bit_idx_r == 7'(mahpm_pkg::FRAME_BITS));
  // the phy launches a read bit after one mdc rise; it is taken just
  // before the next rise, which leaves the phy up to 340 ns of delay
  wire rx_take = low_end & ~cmd_r.mgmt_write_select &
    (bit_idx_r >= 7'(mahpm_pkg::DATA_BIT)) &
    (bit_idx_r < 7'(mahpm_pkg::FRAME_BITS));
  wire drive_nxt = mgmt_busy &
    (bit_idx_r < 7'(mahpm_pkg::FRAME_BITS)) &
    (cmd_r.mgmt_write_select | (bit_idx_r < 7'(mahpm_pkg::TA_BIT)));

  wire [1:0] op_code = pwdata[mahpm_pkg::WRITE_SEL_BIT] ?
    mahpm_pkg::OP_WRITE : mahpm_pkg::OP_READ;
  wire [63:0] frame_load = {mahpm_pkg::PREAMBLE, mahpm_pkg::START_CODE,
    op_code, pwdata[mahpm_pkg::PHY_SEL_LSB +: 5],
    pwdata[mahpm_pkg::REG_SEL_LSB +: 5], mahpm_pkg::TA_WRITE,
    mgmt_data_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r.phy_select <= mahpm_pkg::RST_PHY_SELECT;
      cmd_r.phy_reg_select <= mahpm_pkg::RST_PHY_REG_SELECT;
      cmd_r.mgmt_write_select <= 1'b0;
    end else if (cmd_we) begin
      cmd_r.phy_select <= pwdata[mahpm_pkg::PHY_SEL_LSB +: 5];
      cmd_r.phy_reg_select <= pwdata[mahpm_pkg::REG_SEL_LSB +: 5];
      cmd_r.mgmt_write_select <= pwdata[mahpm_pkg::WRITE_SEL_BIT];
    end
  end

  // a completed read overwrites the word; host writes are dropped while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_data_r <= mahpm_pkg::RST_MGMT_DATA;
    end else if (frame_end & ~cmd_r.mgmt_write_select) begin
      mgmt_data_r <= rx_shift_r;
    end else if (data_we) begin
      mgmt_data_r <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= MG_IDLE;
      ph_r <= 5'd0;
      bit_idx_r <= 7'd0;
      tx_shift_r <= 64'h0;
      rx_shift_r <= 16'h0000;
    end else begin
      unique case (state_r)
        MG_IDLE: begin
          ph_r <= 5'd0;
          bit_idx_r <= 7'd0;
          if (mgmt_start) begin
            state_r <= MG_RUN;
            tx_shift_r <= frame_load;
          end
        end
        MG_RUN: begin
          ph_r <= bit_end ? 5'd0 : ph_r + 5'd1;
          if (rx_take) begin
            rx_shift_r <= {rx_shift_r[14:0], mdio_sync_r};
          end
          if (bit_end) begin
            bit_idx_r <= bit_idx_r + 7'd1;
            tx_shift_r <= {tx_shift_r[62:0], 1'b0};
          end
          if (frame_end) begin
            state_r <= MG_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  // mdio from the phy is asynchronous; only the second stage is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdio_meta_r <= 1'b1;
      mdio_sync_r <= 1'b1;
      mdc_r <= 1'b0;
      mdio_out_r <= 1'b0;
      mdio_oe_r <= 1'b0;
    end else begin
      mdio_meta_r <= mdio_in;
      mdio_sync_r <= mdio_meta_r;
      mdc_r <= mgmt_busy & (ph_r >= half_cyc);
      mdio_out_r <= drive_nxt & tx_shift_r[63];
      mdio_oe_r <= drive_nxt;
    end
  end

  assign mdc = mdc_r;
  assign mdio_out = mdio_out_r;
  assign mdio_oe = mdio_oe_r;

  // ----------------------------------------------------------------------
  // multicast filter
  // ----------------------------------------------------------------------
  mahpm_hash_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .dest_addr(dest_addr),
    .dest_valid(dest_valid),
    .group_hash_bits({hash_high_r, hash_low_r}),
    .verdict(mcast_verdict)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [11:0] busy_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_r <= 12'd0;
    end else begin
      busy_cnt_r <= mgmt_busy ? busy_cnt_r + 12'd1 : 12'd0;
    end
  end

  chk_hash_high_rst: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> hash_high_r == 32'hFFFF_FFFF)
    else $error("upper hash register not all ones after reset");

  chk_hash_low_rst: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> hash_low_r == 32'h0000_0000)
    else $error("lower hash register not zero after reset");

  chk_frame_fields: assert property (
    @(posedge pclk) disable iff (!presetn)
    mgmt_start |=> tx_shift_r[27:23] == cmd_r.phy_select &&
      tx_shift_r[22:18] == cmd_r.phy_reg_select &&
      tx_shift_r[31:30] == 2'h1)
    else $error("frame address fields differ from the command");

  chk_frame_opcode: assert property (
    @(posedge pclk) disable iff (!presetn)
    mgmt_start |=> tx_shift_r[29:28] ==
      (cmd_r.mgmt_write_select ? 2'h1 : 2'h2))
    else $error("frame opcode does not follow the direction bit");

  chk_busy_on_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    mgmt_start |=> cmd_view[0] [*8])
    else $error("in-progress flag not set after start");

  chk_busy_bounded: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy_cnt_r <= 12'd1300)
    else $error("management transaction overran its frame length");

  chk_busy_length: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(mgmt_busy) |-> busy_cnt_r == 12'd1300)
    else $error("in-progress flag did not last one full frame");

  chk_read_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(mgmt_busy) && !cmd_r.mgmt_write_select |->
      mgmt_data_r == $past(rx_shift_r))
    else $error("read data did not reach the data register");

  chk_read_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    mdio_oe_r && !cmd_r.mgmt_write_select |->
      $past(bit_idx_r) < 7'd46)
    else $error("mdio driven after turnaround of a read frame");

  chk_mdc_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(mdc_r) |-> mdc_r [*8])
    else $error("mdc high phase too short");

  chk_other_mac: assert property (
    @(posedge pclk) disable iff (!presetn)
    !IS_FIRST_MAC |-> mgmt_idle && !mdio_oe_r)
    else $error("management logic active in a later mac instance");

  cov_write_frame: cover property (
    @(posedge pclk) disable iff (!presetn)
    frame_end && cmd_r.mgmt_write_select);

  cov_read_frame: cover property (
    @(posedge pclk) disable iff (!presetn)
    frame_end && !cmd_r.mgmt_write_select);

  cov_bad_addr: cover property (
    @(posedge pclk) disable iff (!presetn) pready_r && pslverr_r);

endmodule : mahpm_regs

// File: tb/mahpm_phy_model.sv
`timescale 1ns/1ns
module mahpm_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h03
) (
  // management bus
  input wire logic mdc,
  input wire logic mdio,
  output logic phy_oe,
  output logic phy_d,
  // answer delay after the mdc rise, in ns
  input wire logic [31:0] resp_ns,
  // last frame seen on the wire
  output logic [15:0] last_hdr,
  output logic [15:0] last_data,
  output int frames
);
  logic [15:0] mem [32];
  logic [31:0] sh;
  logic [4:0] ra;
  logic rd_go;
  int pos;
  int ones;

  initial begin
    for (int i = 0; i < 32; i++) mem[i] = {11'h5A3, i[4:0]};
    phy_oe = 1'b0;
    phy_d = 1'b0;
    pos = -1;
    ones = 0;
    frames = 0;
    rd_go = 1'b0;
    sh = 32'h0;
    last_hdr = 16'h0;
    last_data = 16'h0;
  end

  // bits are taken on the mdc rise; answers launch after it
  always @(posedge mdc) begin
    if (pos < 0) begin
      if (ones >= 32 && mdio === 1'b0) pos = 33;
      ones = (mdio === 1'b1) ? ones + 1 : 0;
    end else begin
      sh = {sh[30:0], mdio};
      pos = pos + 1;
      if (pos == 46) begin
        ra = sh[4:0];
        rd_go = (sh[11:10] == 2'b10) && (sh[9:5] == PHY_ADDR);
      end
      if (rd_go && pos >= 47 && pos <= 64) begin
        #(resp_ns);
        phy_oe = (pos < 64);
        phy_d = (pos == 47 || pos == 64) ? 1'b0 : mem[ra][63 - pos];
      end
      if (pos == 64) begin
        last_hdr = {1'b0, sh[30:16]};
        last_data = sh[15:0];
        if (sh[29:28] == 2'b01 && sh[27:23] == PHY_ADDR) begin
          mem[sh[22:18]] = sh[15:0];
        end
        frames = frames + 1;
        pos = -1;
        ones = 0;
        rd_go = 1'b0;
      end
    end
  end
endmodule : mahpm_phy_model

// File: tb/mahpm_regs_tb.sv
`timescale 1ns/1ns
module mahpm_regs_tb;
  localparam logic [4:0] PHY_A = 5'h03;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tgt = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [47:0] dest_addr = 48'h0;
  logic dest_valid = 0;
  logic [31:0] prdata, prdata_a, prdata_b, sta_bits, r;
  logic pready, pready_a, pready_b, pslverr, pslverr_a, pslverr_b, e;
  logic mdc, mdio_out, mdio_oe, mdio_w, phy_oe, phy_d, mdc_b, oe_b;
  mahpm_pkg::mahpm_filt_type verdict;
  logic [15:0] hdr, pdata;
  logic [47:0] fa [4] = '{48'h0100_5E00_0001, 48'h3333_0000_0001,
                          48'hFFFF_FFFF_FFFF, 48'h0180_C200_0001};
  logic [4:0] cpa [3] = '{PHY_A, PHY_A, 5'h1C};
  logic [4:0] cra [3] = '{5'h09, 5'h1F, 5'h09};
  logic [15:0] cex [3] = '{16'hBEEF, 16'hB47F, 16'hFFFF};
  int cns [3] = '{0, 300, 0};
  int frames, resp_ns = 0, num_errors = 0, n_tests = 0;

  always #10 pclk = ~pclk;
  assign pready = tgt ? pready_b : pready_a;
  assign pslverr = tgt ? pslverr_b : pslverr_a;
  assign prdata = tgt ? prdata_b : prdata_a;
  // the line has a pull-up, so a released bus reads one
  assign mdio_w = mdio_oe ? mdio_out : (phy_oe ? phy_d : 1'b1);

  mahpm_regs #(.IS_FIRST_MAC(1'b1)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel & ~tgt), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_a), .pready(pready_a),
    .pslverr(pslverr_a), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .dest_addr(dest_addr), .dest_valid(dest_valid),
    .station_addr_bits(sta_bits), .mcast_verdict(verdict));
  mahpm_regs #(.IS_FIRST_MAC(1'b0)) dut_b (.pclk(pclk), .presetn(presetn),
    .psel(psel & tgt), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_b), .pready(pready_b),
    .pslverr(pslverr_b), .mdc(mdc_b), .mdio_in(1'b1), .mdio_out(),
    .mdio_oe(oe_b), .dest_addr(dest_addr), .dest_valid(dest_valid),
    .station_addr_bits(), .mcast_verdict());
  mahpm_phy_model #(.PHY_ADDR(PHY_A)) phy_u (.mdc(mdc), .mdio(mdio_w),
    .phy_oe(phy_oe), .phy_d(phy_d), .resp_ns(resp_ns), .last_hdr(hdr),
    .last_data(pdata), .frames(frames));

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready", 0, 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1, a, d, x, y);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] exp, input logic exp_err);
    logic [31:0] x;
    logic y;
    apb(0, a, 32'h0, x, y);
    check(what, x, exp);
    check({what, " err"}, {31'h0, y}, {31'h0, exp_err});
  endtask : rd

  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    logic fb;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 8; j++) begin
        fb = c[31] ^ a[40 - 8 * i + j];
        c = {c[30:0], 1'b0} ^ (fb ? 32'h04C1_1DB7 : 32'h0);
      end
    end
    return c[31:26];
  endfunction : hidx

  task automatic filt(input logic [47:0] a, input logic [63:0] tbl);
    logic [5:0] k;
    k = hidx(a);
    @(posedge pclk);
    dest_addr <= a;
    dest_valid <= 1;
    @(posedge pclk);
    dest_valid <= 0;
    @(posedge pclk);
    check("verdict", {30'h0, verdict}, {30'h0, tbl[k], 1'b1});
  endtask : filt

  task automatic mgmt(input logic [4:0] pa, input logic [4:0] ra,
                      input logic w);
    logic [31:0] c;
    logic [31:0] x;
    logic y;
    int n;
    c = {16'h0, pa, ra, 4'h0, w, 1'b0};
    n = 0;
    wr(mahpm_pkg::OFF_PHY_MGMT_COMMAND, c);
    rd("busy", mahpm_pkg::OFF_PHY_MGMT_COMMAND, c | 32'h1, 0);
    wr(mahpm_pkg::OFF_PHY_MGMT_DATA, 32'h1234);
    wr(mahpm_pkg::OFF_PHY_MGMT_COMMAND, 32'h0);
    repeat (1270) @(posedge pclk);
    rd("still busy", mahpm_pkg::OFF_PHY_MGMT_COMMAND, c | 32'h1, 0);
    do begin
      apb(0, mahpm_pkg::OFF_PHY_MGMT_COMMAND, 32'h0, x, y);
      n++;
    end while (x[0] !== 1'b0 && n < 12);
    check("busy end", x, c);
  endtask : mgmt

  task automatic print_verdict;
    $display("checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    check("mdc idle", {30'h0, mdc, mdio_oe}, 0);
    check("station bits", sta_bits, 32'hFFFF_FFFF);
    rd("sal rst", mahpm_pkg::OFF_STATION_ADDR_LOW, 32'hFFFF_FFFF, 0);
    rd("ghh rst", mahpm_pkg::OFF_GROUP_HASH_HIGH, 32'hFFFF_FFFF, 0);
    rd("ghl rst", mahpm_pkg::OFF_GROUP_HASH_LOW, 32'h0, 0);
    rd("cmd rst", mahpm_pkg::OFF_PHY_MGMT_COMMAND, 32'h5AC0, 0);
    rd("data rst", mahpm_pkg::OFF_PHY_MGMT_DATA, 32'h0, 0);
    wr(mahpm_pkg::OFF_STATION_ADDR_LOW, 32'hA5C3_0F96);
    rd("sal", mahpm_pkg::OFF_STATION_ADDR_LOW, 32'hA5C3_0F96, 0);
    check("station bits", sta_bits, 32'hA5C3_0F96);
    apb(1, 8'h04, 32'h1, r, e);
    check("bad wr err", {31'h0, e}, 1);
    rd("bad rd", 8'h1C, 32'h0, 1);
    for (int i = 0; i < 4; i++) filt(fa[i], {32'hFFFF_FFFF, 32'h0});
    wr(mahpm_pkg::OFF_GROUP_HASH_HIGH, 32'h0123_4567);
    wr(mahpm_pkg::OFF_GROUP_HASH_LOW, 32'h89AB_CDEF);
    rd("ghh", mahpm_pkg::OFF_GROUP_HASH_HIGH, 32'h0123_4567, 0);
    rd("ghl", mahpm_pkg::OFF_GROUP_HASH_LOW, 32'h89AB_CDEF, 0);
    for (int i = 0; i < 4; i++) filt(fa[i], 64'h0123_4567_89AB_CDEF);
    wr(mahpm_pkg::OFF_PHY_MGMT_DATA, 32'hFFFF_BEEF);
    rd("data", mahpm_pkg::OFF_PHY_MGMT_DATA, 32'h0000_BEEF, 0);
    mgmt(PHY_A, 5'h09, 1'b1);
    check("wr hdr", hdr, {4'b0101, PHY_A, 5'h09, 2'b10});
    check("wr data", pdata, 16'hBEEF);
    for (int i = 0; i < 3; i++) begin
      resp_ns = cns[i];
      mgmt(cpa[i], cra[i], 1'b0);
      // with no phy answering, the pull-up holds both turnaround bits
      check("rd hdr", hdr, {4'b0110, cpa[i], cra[i], 1'b1,
            cpa[i] != PHY_A});
      rd("rd data", mahpm_pkg::OFF_PHY_MGMT_DATA, cex[i], 0);
    end
    check("frames", frames, 4);
    tgt <= 1;
    wr(mahpm_pkg::OFF_PHY_MGMT_DATA, 32'h55);
    wr(mahpm_pkg::OFF_PHY_MGMT_COMMAND, 32'h1842);
    rd("mac2 cmd", mahpm_pkg::OFF_PHY_MGMT_COMMAND, 32'h0, 0);
    rd("mac2 data", mahpm_pkg::OFF_PHY_MGMT_DATA, 32'h0, 0);
    repeat (40) @(posedge pclk);
    check("mac2 bus", {30'h0, mdc_b, oe_b}, 0);
    print_verdict();
  end

  // about 5400 cycles are expected; stop at 20000
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
endmodule : mahpm_regs_tb
